/* output_mode_defines.vh */
/*
 Register offsets, field positions and reset values of the output-mode
 control bank. Assumes an APB slave with byte addresses derived from the
 register index (index times four).
*/
`ifndef OUTPUT_MODE_DEFINES_VH
`define OUTPUT_MODE_DEFINES_VH

// Register indices as printed
`define IDX_CTRL_SEL_LOW 12'h559
`define IDX_CTRL_SEL_HIGH 12'h55A
`define IDX_SAMPLE_FMT 12'h561
`define IDX_OVR_CLEAR 12'h562
`define IDX_OVR_STATUS 12'h563
`define IDX_CHAN_ORDER 12'h564
`define IDX_LANE_RATE 12'h56E
`define IDX_QUICK_SETUP 12'h570
`define IDX_CS_COUNT 12'h58F
`define IDX_IRQ_MASK 12'h600

// Reset values
`define RST_CTRL_SEL_LOW 8'h00
`define RST_CTRL_SEL_HIGH 8'h00
`define RST_SAMPLE_FMT 8'h01
`define RST_OVR_CLEAR 8'h00
`define RST_CHAN_ORDER 8'h00
`define RST_LANE_RATE 8'h10
`define RST_QUICK_SETUP 8'h88
`define RST_CS_COUNT 8'h00
`define RST_IRQ_MASK 8'h00

// Write masks (reserved bits read zero)
`define WMASK_CTRL_SEL_LOW 8'h77
`define WMASK_CTRL_SEL_HIGH 8'h07
`define WMASK_SAMPLE_FMT 8'h07
`define WMASK_CHAN_ORDER 8'h01
`define WMASK_LANE_RATE 8'h10
`define WMASK_CS_COUNT 8'h03

// Field positions
`define SEL0_LSB 0
`define SEL1_LSB 4
`define SEL2_LSB 0
`define INVERT_BIT 2
`define FORMAT_LSB 0
`define SWAP_BIT 0

// Control-bit source codes
`define SRC_ZERO 3'h0
`define SRC_OVERRANGE 3'h1
`define SRC_SIGMON 3'h2
`define SRC_FAST_DETECT 3'h3
`define SRC_SYSREF 3'h5

`endif

/* ctrl_bit_mux.v */
/*
 Selects the source of one appended control bit of a sample.
 Assumes all flags are synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "output_mode_defines.vh"

module ctrl_bit_mux (
  input wire [2:0] sel,
  input wire overrange,
  input wire sig_monitor,
  input wire fast_detect_flag,
  input wire sysref,
  output reg bit_out
);

  // Source decode; unlisted codes give zero
  always @* begin
    case (sel)
      `SRC_OVERRANGE: bit_out = overrange;
      `SRC_SIGMON: bit_out = sig_monitor;
      `SRC_FAST_DETECT: bit_out = fast_detect_flag;
      `SRC_SYSREF: bit_out = sysref;
      default: bit_out = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

/* sample_format.v */
/*
 Formats one 14-bit sample: optional two's complement and inversion.
 Assumes input samples are offset binary.
*/
`timescale 1ns/1ps
`default_nettype none

module sample_format (
  input wire [13:0] din,
  input wire [1:0] fmt,
  input wire invert,
  output wire [13:0] dout
);

  wire [13:0] coded;

  // Two's complement flips the MSB of offset binary
  assign coded = (fmt == 2'h1) ? {~din[13], din[12:0]} : din;
  assign dout = invert ? ~coded : coded;

endmodule
`default_nettype wire

/* output_mode_control.v */
/*
 Output-mode control bank: APB registers, control-bit selection, sample
 inversion, overrange status per virtual converter, channel swap and an
 interrupt. Assumes samples, flags and APB all run on pclk.
*/
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "output_mode_defines.vh"

module output_mode_control (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [13:0] sample_a,
  input wire [13:0] sample_b,
  input wire [1:0] sig_monitor,
  input wire [1:0] fast_detect_flag,
  input wire sysref,
  input wire [7:0] overrange_in,
  output reg [15:0] out_a,
  output reg [15:0] out_b,
  output reg irq
);

  reg [7:0] ctrl_sel_low_reg;
  reg [7:0] ctrl_sel_high_reg;
  reg [7:0] sample_fmt_reg;
  reg [7:0] ovr_clear_reg;
  reg [7:0] ovr_status_reg;
  reg [7:0] chan_order_reg;
  reg [7:0] lane_rate_reg;
  reg [7:0] quick_setup_reg;
  reg [7:0] cs_count_reg;
  reg [7:0] irq_mask_reg;
  reg [7:0] ovr_status_next;
  reg [7:0] rd_next;
  reg hit_next;
  reg [7:0] wb;

  wire access;
  wire wr_en;
  wire [11:0] idx;
  wire aligned;
  wire [13:0] fmt_a;
  wire [13:0] fmt_b;
  wire [2:0] cbit_a;
  wire [2:0] cbit_b;
  wire [15:0] word_a;
  wire [15:0] word_b;

  // Access phase; slave answers after one wait state
  assign access = psel & penable & ~pready;
  assign wr_en = access & pwrite;
  assign idx = paddr[13:2];
  assign aligned = (paddr[1:0] == 2'h0) & (paddr[31:14] == 18'h0);

  // Address decode and read mux
  always @* begin
    hit_next = aligned;
    rd_next = 8'h00;
    case (idx)
      `IDX_CTRL_SEL_LOW: rd_next = ctrl_sel_low_reg;
      `IDX_CTRL_SEL_HIGH: rd_next = ctrl_sel_high_reg;
      `IDX_SAMPLE_FMT: rd_next = sample_fmt_reg;
      `IDX_OVR_CLEAR: rd_next = ovr_clear_reg;
      `IDX_OVR_STATUS: rd_next = ovr_status_reg;
      `IDX_CHAN_ORDER: rd_next = chan_order_reg;
      `IDX_LANE_RATE: rd_next = lane_rate_reg;
      `IDX_QUICK_SETUP: rd_next = quick_setup_reg;
      `IDX_CS_COUNT: rd_next = cs_count_reg;
      `IDX_IRQ_MASK: rd_next = irq_mask_reg;
      default: hit_next = 1'b0;
    endcase
    wb = pwdata[7:0];
  end

  // APB answer, registered: one wait state per access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access;
      pslverr <= access & ~hit_next;
      if (access && !pwrite && hit_next) begin
        prdata <= {24'h000000, rd_next};
      end else if (access) begin
        prdata <= 32'h00000000;
      end
    end
  end

  // Writable configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sel_low_reg <= `RST_CTRL_SEL_LOW;
      ctrl_sel_high_reg <= `RST_CTRL_SEL_HIGH;
      sample_fmt_reg <= `RST_SAMPLE_FMT;
      ovr_clear_reg <= `RST_OVR_CLEAR;
      chan_order_reg <= `RST_CHAN_ORDER;
      lane_rate_reg <= `RST_LANE_RATE;
      quick_setup_reg <= `RST_QUICK_SETUP;
      cs_count_reg <= `RST_CS_COUNT;
      irq_mask_reg <= `RST_IRQ_MASK;
    end else if (wr_en && aligned) begin
      case (idx)
        `IDX_CTRL_SEL_LOW: ctrl_sel_low_reg <= wb & `WMASK_CTRL_SEL_LOW;
        `IDX_CTRL_SEL_HIGH: ctrl_sel_high_reg <= wb & `WMASK_CTRL_SEL_HIGH;
        `IDX_SAMPLE_FMT: sample_fmt_reg <= wb & `WMASK_SAMPLE_FMT;
        `IDX_OVR_CLEAR: ovr_clear_reg <= wb;
        `IDX_CHAN_ORDER: chan_order_reg <= wb & `WMASK_CHAN_ORDER;
        `IDX_LANE_RATE: lane_rate_reg <= wb & `WMASK_LANE_RATE;
        `IDX_QUICK_SETUP: quick_setup_reg <= wb;
        `IDX_CS_COUNT: cs_count_reg <= wb & `WMASK_CS_COUNT;
        `IDX_IRQ_MASK: irq_mask_reg <= wb;
        default: ovr_clear_reg <= ovr_clear_reg;
      endcase
    end
  end

  // Overrange status per virtual converter
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : ovr_bits
      always @* begin
        if (overrange_in[g]) begin
          ovr_status_next[g] = 1'b1; // New event wins over clear
        end else if (ovr_clear_reg[g]) begin
          ovr_status_next[g] = 1'b0; // Clear bit held high empties flag in cycles without an event
        end else if (wr_en && aligned && idx == `IDX_OVR_STATUS && wb[g]) begin
          ovr_status_next[g] = 1'b0; // Write one to clear
        end else begin
          ovr_status_next[g] = ovr_status_reg[g];
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_status_reg <= 8'h00;
      irq <= 1'b0;
    end else begin
      ovr_status_reg <= ovr_status_next;
      irq <= |(ovr_status_next & irq_mask_reg);
    end
  end

  // Per channel formatting
  // sample invert
  sample_format fmt_a_i (
    .din(sample_a),
    .fmt(sample_fmt_reg[1:0]),
    .invert(sample_fmt_reg[`INVERT_BIT]),
    .dout(fmt_a)
  );

  sample_format fmt_b_i (
    .din(sample_b),
    .fmt(sample_fmt_reg[1:0]),
    .invert(sample_fmt_reg[`INVERT_BIT]),
    .dout(fmt_b)
  );

  // Control-bit selection; channel a uses converter 0 flag, b converter 1
  generate
    for (g = 0; g < 3; g = g + 1) begin : cbits
      wire [2:0] sel;
      assign sel = (g == 2) ? ctrl_sel_high_reg[2:0] :
                   (g == 1) ? ctrl_sel_low_reg[6:4] : ctrl_sel_low_reg[2:0];
      ctrl_bit_mux mux_a (
        .sel(sel),
        .overrange(overrange_in[0]),
        .sig_monitor(sig_monitor[0]),
        .fast_detect_flag(fast_detect_flag[0]),
        .sysref(sysref),
        .bit_out(cbit_a[g])
      );
      ctrl_bit_mux mux_b (
        .sel(sel),
        .overrange(overrange_in[1]),
        .sig_monitor(sig_monitor[1]),
        .fast_detect_flag(fast_detect_flag[1]),
        .sysref(sysref),
        .bit_out(cbit_b[g])
      );
    end
  endgenerate

  // Insertion follows the control-bit count: 1 keeps bit 2, 2 adds 1, 3 adds 0
  // count gating
  assign word_a = {fmt_a, 2'h0} |
    {13'h0000, (cs_count_reg[1:0] != 2'h0) & cbit_a[2],
     (cs_count_reg[1:0] >= 2'h2) & cbit_a[1], (cs_count_reg[1:0] == 2'h3) & cbit_a[0]};
  assign word_b = {fmt_b, 2'h0} |
    {13'h0000, (cs_count_reg[1:0] != 2'h0) & cbit_b[2],
     (cs_count_reg[1:0] >= 2'h2) & cbit_b[1], (cs_count_reg[1:0] == 2'h3) & cbit_b[0]};

  // Registered outputs with optional swap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a <= 16'h0000;
      out_b <= 16'h0000;
    end else if (chan_order_reg[`SWAP_BIT]) begin
      out_a <= word_b;
      out_b <= word_a;
    end else begin
      out_a <= word_a;
      out_b <= word_b;
    end
  end

endmodule
`default_nettype wire

/* output_mode_control_checker.sv */
/* Assertions for the output-mode bank.
   Assumes a bind onto the top module ports; one clock. */
`timescale 1ns/1ps
`default_nettype none
module output_mode_control_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [13:0] sample_a,
  input wire logic [13:0] sample_b,
  input wire logic [1:0] sig_monitor,
  input wire logic [1:0] fast_detect_flag,
  input wire logic sysref,
  input wire logic [7:0] overrange_in,
  input wire logic [15:0] out_a,
  input wire logic [15:0] out_b,
  input wire logic irq
);
  logic [7:0] lo, hi, fm, clr, sw, cs, msk;
  logic [15:0] qa, qb;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  function automatic logic pick(input logic [2:0] s, input int k);
    case (s)
      3'h1: pick = overrange_in[k];
      3'h2: pick = sig_monitor[k];
      3'h3: pick = fast_detect_flag[k];
      3'h5: pick = sysref;
      default: pick = 1'b0;
    endcase
  endfunction
  function automatic logic [15:0] word(input logic [13:0] s, input int k);
    logic [13:0] v;
    logic [2:0] c;
    v = (s ^ {fm[1:0] == 2'b01, 13'h0}) ^ {14{fm[2]}};
    c[2] = cs[1:0] != 2'b00 && pick(hi[2:0], k);
    c[1] = cs[1:0] > 2'b01 && pick(lo[6:4], k);
    c[0] = cs[1:0] == 2'b11 && pick(lo[2:0], k);
    word = {v, 2'b00} | {13'h0, c};
  endfunction
  // Shadow copy, updated at the edge that takes a write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {lo, hi, fm, clr, sw, cs, msk} <= 56'h00000100000000;
    end else if (psel && penable && !pready && pwrite && paddr[31:16] == 16'h0) begin
      case (paddr[15:0])
        16'h1564: lo <= pwdata[7:0] & 8'h77;
        16'h1568: hi <= pwdata[7:0] & 8'h07;
        16'h1584: fm <= pwdata[7:0] & 8'h07;
        16'h1588: clr <= pwdata[7:0];
        16'h1590: sw <= pwdata[7:0] & 8'h01;
        16'h163C: cs <= pwdata[7:0] & 8'h03;
        16'h1800: msk <= pwdata[7:0];
        default: ;
      endcase
    end
  end
  // Expected words, one cycle behind like the outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      {qa, qb} <= 32'h0;
    else
      // Swap moves whole words, control bits of the other channel included
      {qa, qb} <= sw[0] ? {word(sample_b, 1), word(sample_a, 0)} :
        {word(sample_a, 0), word(sample_b, 1)};
  end
  sequence s_calm;
    clr == 8'hFF && overrange_in == 8'h00;
  endsequence
  property p_word_a;
    out_a == qa;
  endproperty
  property p_word_b;
    out_b == qb;
  endproperty
  property p_cs_gate;
    cs[1:0] == 2'b00 |=> out_a[1:0] == 2'b00 && out_b[1:0] == 2'b00;
  endproperty
  property p_status;
    (|(overrange_in & msk)) && !psel |-> ##1 irq;
  endproperty
  property p_clear;
    s_calm ##1 s_calm |=> !irq;
  endproperty
  property p_mask;
    msk == 8'h00 |=> !irq;
  endproperty
  property p_ready;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_word_a: assert property (p_word_a) else $error("out_a word wrong");
  a_word_b: assert property (p_word_b) else $error("out_b word wrong");
  a_cs_gate: assert property (p_cs_gate) else $error("control bits leak");
  a_status: assert property (p_status) else $error("irq missed event");
  a_clear: assert property (p_clear) else $error("clear ignored");
  a_mask: assert property (p_mask) else $error("masked irq high");
  a_ready: assert property (p_ready) else $error("pready timing");
endmodule
`default_nettype wire

/* link_receiver.sv */
/* Far-side receiver of the two sample words.
   Assumes it takes both words at every rising pclk. */
`timescale 1ns/1ps
`default_nettype none
module link_receiver (
  input wire logic pclk,
  input wire logic [15:0] word_a,
  input wire logic [15:0] word_b,
  output logic [15:0] got_a,
  output logic [15:0] got_b
);
  // No flow control: a word per clock, as the framer sends
  always @(posedge pclk) begin
    got_a <= word_a;
    got_b <= word_b;
  end
endmodule
`default_nettype wire

/* output_mode_control_tb.sv */
/* Bench for the output-mode bank over APB.
   Assumes the checker and receiver compile first. */
`timescale 1ns/1ps
`default_nettype none
`define CK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module output_mode_control_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sysref, irq, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [13:0] sample_a, sample_b;
  logic [1:0] sig_monitor, fast_detect_flag;
  logic [7:0] overrange_in;
  logic [15:0] out_a, out_b, got_a, got_b;
  int n_mismatch, comparisons, cyc;
  logic [31:0] ra [8] = '{32'h1564, 32'h1568, 32'h1584, 32'h1588, 32'h158C, 32'h1590,
    32'h15B8, 32'h15C0};
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h10, 8'h88};
  logic [2:0] code [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
  logic [3:0] hot [5] = '{4'hF, 4'h8, 4'h4, 4'h2, 4'h1};
  output_mode_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_a(sample_a), .sample_b(sample_b), .sig_monitor(sig_monitor),
    .fast_detect_flag(fast_detect_flag), .sysref(sysref), .overrange_in(overrange_in),
    .out_a(out_a), .out_b(out_b), .irq(irq));
  link_receiver far (.pclk(pclk), .word_a(out_a), .word_b(out_b), .got_a(got_a),
    .got_b(got_b));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Hang guard, well above the few hundred cycles used
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One APB transfer; holds the request until pready
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    {psel, penable, pwrite, sysref, presetn} = 5'h0;
    {paddr, pwdata} = 64'h0;
    {sample_a, sample_b, sig_monitor, fast_detect_flag, overrange_in} = 40'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, ra[i], 32'h0);
      `CK(rd[7:0], rv[i])
    end
    xfer(1'b1, 32'h00001000, 32'hFF);
    `CK(er, 1'b1)
    xfer(1'b1, 32'h1584, 32'h0);
    xfer(1'b1, 32'h163C, 32'h3);
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, 32'h1564, {25'h0, code[i], 1'b0, code[i]});
      xfer(1'b1, 32'h1568, {29'h0, code[i]});
      {overrange_in[0], sig_monitor[0], fast_detect_flag[0], sysref} <= hot[i];
      repeat (3) @(posedge pclk);
      `CK(got_a[2:0], (i == 0) ? 3'h0 : 3'h7)
    end
    xfer(1'b1, 32'h1564, 32'h11);
    xfer(1'b1, 32'h1568, 32'h1);
    overrange_in <= 8'h01;
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 32'h163C, c);
      repeat (3) @(posedge pclk);
      `CK(got_a[2:0], {c > 0, c > 1, c == 3})
    end
    overrange_in <= 8'h00;
    sample_a <= 14'h0123;
    sample_b <= 14'h2ABC;
    xfer(1'b1, 32'h163C, 32'h0);
    xfer(1'b1, 32'h1584, 32'h4);
    repeat (3) @(posedge pclk);
    `CK(got_a, {14'h3EDC, 2'b00})
    xfer(1'b1, 32'h1590, 32'h1);
    repeat (3) @(posedge pclk);
    `CK(got_a, {14'h1543, 2'b00})
    `CK(got_b, {14'h3EDC, 2'b00})
    xfer(1'b1, 32'h158C, 32'hFF);
    overrange_in <= 8'h81;
    @(posedge pclk);
    overrange_in <= 8'h00;
    xfer(1'b0, 32'h158C, 32'h0);
    `CK(rd[7:0], 8'h81)
    `CK(irq, 1'b0)
    xfer(1'b1, 32'h1800, 32'h80);
    `CK(irq, 1'b1)
    xfer(1'b1, 32'h1588, 32'hFF);
    repeat (2) @(posedge pclk);
    xfer(1'b0, 32'h158C, 32'h0);
    `CK(rd[7:0], 8'h00)
    `CK(irq, 1'b0)
    xfer(1'b1, 32'h1588, 32'h0);
    overrange_in <= 8'h80;
    repeat (3) @(posedge pclk);
    `CK(irq, 1'b1)
    wrap_up();
  end
endmodule
bind output_mode_control output_mode_control_checker chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .sample_a(sample_a), .sample_b(sample_b), .sig_monitor(sig_monitor),
  .fast_detect_flag(fast_detect_flag), .sysref(sysref), .overrange_in(overrange_in),
  .out_a(out_a), .out_b(out_b), .irq(irq));
`default_nettype wire
